// File: logic/timer_pkg.sv
// Register map, reset values and shared types of the auto-reload timer.
// Assumes one clock domain and an AXI4-Lite master driving the registers.
package timer_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] CTRL_OFS      = 8'hc8;
  localparam logic [7:0] RELOAD_LO_OFS = 8'hcc;
  localparam logic [7:0] RELOAD_HI_OFS = 8'hd0;
  localparam logic [7:0] COUNT_LO_OFS  = 8'hd4;
  localparam logic [7:0] COUNT_HI_OFS  = 8'hd8;
  localparam logic [7:0] CLKSEL_OFS    = 8'hdc;
  localparam logic [7:0] CORE_IE_OFS   = 8'he0;
  localparam logic [7:0] STATUS_OFS    = 8'he4;
  localparam logic [7:0] MASK_OFS      = 8'he8;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] RELOAD_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [1:0] CLKSEL_RST  = 2'h0;
  localparam logic       CORE_IE_RST = 1'h0;
  localparam logic [1:0] MASK_RST    = 2'h3;
  localparam int         CKS_LO      = 0;
  localparam int         CKS_HI      = 1;
  localparam int         ST_HI       = 0;
  localparam int         ST_LO       = 1;

  // ----------------------------------------------------------------
  // Prescaler counts and bus answers
  // ----------------------------------------------------------------
  localparam logic [3:0] DIV12_LAST   = 4'hb;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;

  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_interrupt_enable;
    logic lf_capture_enable;
    logic split_mode_select;
    logic high_run_control;
    logic unused;
    logic external_clock_select;
  } ctrl_t;

  typedef struct packed {
    logic sys_div12;
    logic ext_div8;
  } tick_src_t;

  typedef enum logic [3:0] {
    SEL_CTRL, SEL_RLO, SEL_RHI, SEL_CLO, SEL_CHI,
    SEL_CKS, SEL_IE, SEL_STAT, SEL_MASK, SEL_NONE
  } reg_sel_t;

endpackage

// File: logic/tick_gen.sv
// Counting-clock prescalers: system clock / 12 and external clock / 8.
// Assumes ext_osc is slower than half of mclk.
module tick_gen (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              ext_osc,
  output timer_pkg::tick_src_t   ticks
);
  logic [3:0] div12_reg;
  logic       sync1_reg;
  logic       sync2_reg;
  logic       sync3_reg;
  logic [2:0] ext_cnt_reg;
  logic       ext_rise;

  assign ext_rise = sync2_reg & ~sync3_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      div12_reg   <= 4'h0;
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      sync3_reg   <= 1'b0;
      ext_cnt_reg <= 3'h0;
    end else begin
      div12_reg   <= (div12_reg == timer_pkg::DIV12_LAST) ? 4'h0
                     : div12_reg + 4'h1;
      sync1_reg   <= ext_osc;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      if (ext_rise) begin
        ext_cnt_reg <= ext_cnt_reg + 3'h1;
      end
    end
  end

  assign ticks.sys_div12 = (div12_reg == timer_pkg::DIV12_LAST);
  assign ticks.ext_div8  = ext_rise &
                           (ext_cnt_reg == timer_pkg::EXT_DIV_LAST);
endmodule // tick_gen

// File: logic/byte_counter.sv
// One count byte with software load and reload on wrap.
// Assumes inc is a one-cycle pulse per counting-clock tick.
module byte_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_val,
  input  wire logic             inc,
  input  wire logic             reload_wrap,
  input  wire logic [WIDTH-1:0] reload_val,
  output logic      [WIDTH-1:0] count,
  output logic                  at_max,
  output logic                  wrap
);
  assign at_max = &count;
  // Software load wins, so no wrap is reported under a write
  assign wrap   = inc & at_max & ~wr_en;

  always_ff @(posedge mclk) begin
    if (srst) begin
      count <= WIDTH'(timer_pkg::COUNT_RST);
    end else if (wr_en) begin
      count <= wr_val;
    end else if (wrap) begin
      count <= reload_wrap ? reload_val : '0;
    end else if (inc) begin
      count <= count + WIDTH'(1);
    end
  end
endmodule // byte_counter

// File: logic/auto_reload_timer.sv
// Auto-reload timer, 16-bit or split 8-bit, with AXI4-Lite registers.
// Assumes one clock mclk; ext_osc is the raw external oscillator.
// Behaviour
// - Count held as two 8-bit bytes
// - Control bit 3 selects split mode
// - Clocks: system, system/12, external/8
// - External clock synchronised before counting
// - 16-bit wrap reloads both bytes, sets high flag
// - 16-bit overflow interrupts when enabled
// - Low-byte wrap interrupts with low enable
// - Split bytes reload from own registers
// - Run bit gates both bytes in 16-bit mode, high byte only in split
// - Per-byte select: system or shared source
// - Split wraps set respective overflow flags
// - Split interrupts: high, or either with enable
// - Flags cleared only by software
module auto_reload_timer (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        ext_osc,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  timer_pkg::ctrl_t     ctrl_reg;
  timer_pkg::ctrl_t     ctrl_next;
  timer_pkg::tick_src_t ticks;
  timer_pkg::reg_sel_t  wsel;
  timer_pkg::reg_sel_t  rsel;
  logic [7:0]           reload_lo_reg;
  logic [7:0]           reload_hi_reg;
  logic [1:0]           clksel_reg;
  logic [1:0]           mask_reg;
  logic                 core_ie_reg;
  logic                 irq_next;
  logic [7:0]           awaddr_reg;
  logic [7:0]           wbyte_reg;
  logic                 wen_reg;
  logic                 do_write;
  logic                 wr_on;
  logic                 wr_ctrl;
  logic                 wr_stat;
  logic                 wr_clo;
  logic                 wr_chi;
  logic [1:0]           stat_clr;
  logic [7:0]           rd_byte;
  logic [7:0]           cnt_lo;
  logic [7:0]           cnt_hi;
  logic                 lo_at_max;
  logic                 hi_at_max;
  logic                 lo_wrap;
  logic                 hi_wrap;
  logic                 tick_lo;
  logic                 tick_hi;
  logic                 lo_inc;
  logic                 hi_inc;
  logic                 split;
  logic                 run;
  logic [1:0]           evt;

  function automatic timer_pkg::reg_sel_t reg_index(input logic [7:0] a);
    unique case (a)
      timer_pkg::CTRL_OFS:      reg_index = timer_pkg::SEL_CTRL;
      timer_pkg::RELOAD_LO_OFS: reg_index = timer_pkg::SEL_RLO;
      timer_pkg::RELOAD_HI_OFS: reg_index = timer_pkg::SEL_RHI;
      timer_pkg::COUNT_LO_OFS:  reg_index = timer_pkg::SEL_CLO;
      timer_pkg::COUNT_HI_OFS:  reg_index = timer_pkg::SEL_CHI;
      timer_pkg::CLKSEL_OFS:    reg_index = timer_pkg::SEL_CKS;
      timer_pkg::CORE_IE_OFS:   reg_index = timer_pkg::SEL_IE;
      timer_pkg::STATUS_OFS:    reg_index = timer_pkg::SEL_STAT;
      timer_pkg::MASK_OFS:      reg_index = timer_pkg::SEL_MASK;
      default:                  reg_index = timer_pkg::SEL_NONE;
    endcase
  endfunction

  // System clock or the shared source
  function automatic logic pick_tick(input logic use_sys,
                                     input logic ext_sel,
                                     input timer_pkg::tick_src_t t);
    pick_tick = use_sys | (ext_sel ? t.ext_div8 : t.sys_div12);
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are held until the response is accepted
  assign do_write = ~awready & ~wready & ~bvalid;
  assign wsel     = reg_index(awaddr_reg);
  assign rsel     = reg_index(araddr);
  assign wr_on    = do_write & wen_reg & (wsel != timer_pkg::SEL_NONE);
  assign wr_ctrl  = wr_on & (wsel == timer_pkg::SEL_CTRL);
  assign wr_stat  = wr_on & (wsel == timer_pkg::SEL_STAT);
  assign wr_clo   = wr_on & (wsel == timer_pkg::SEL_CLO);
  assign wr_chi   = wr_on & (wsel == timer_pkg::SEL_CHI);
  assign stat_clr = wr_stat ? wbyte_reg[1:0] : 2'h0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= timer_pkg::RESP_OKAY;
      awaddr_reg <= 8'h00;
      wbyte_reg  <= 8'h00;
      wen_reg    <= 1'b0;
    end else begin
      if (awvalid & awready) begin
        awready    <= 1'b0;
        awaddr_reg <= awaddr;
      end
      if (wvalid & wready) begin
        wready    <= 1'b0;
        wbyte_reg <= wdata[7:0];
        wen_reg   <= wstrb[0];
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= (wsel == timer_pkg::SEL_NONE) ? timer_pkg::RESP_DECERR
                  : timer_pkg::RESP_OKAY;
      end
      if (bvalid & bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  assign rd_byte =
    (rsel == timer_pkg::SEL_CTRL) ? ctrl_reg :
    (rsel == timer_pkg::SEL_RLO)  ? reload_lo_reg :
    (rsel == timer_pkg::SEL_RHI)  ? reload_hi_reg :
    (rsel == timer_pkg::SEL_CLO)  ? cnt_lo :
    (rsel == timer_pkg::SEL_CHI)  ? cnt_hi :
    (rsel == timer_pkg::SEL_CKS)  ? {6'h00, clksel_reg} :
    (rsel == timer_pkg::SEL_IE)   ? {7'h00, core_ie_reg} :
    (rsel == timer_pkg::SEL_STAT) ?
      {6'h00, ctrl_reg.low_overflow_flag, ctrl_reg.high_overflow_flag} :
    (rsel == timer_pkg::SEL_MASK) ? {6'h00, mask_reg} : 8'h00;

  always_ff @(posedge mclk) begin
    if (srst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= timer_pkg::RESP_OKAY;
    end else if (arvalid & arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rd_byte};
      rresp   <= (rsel == timer_pkg::SEL_NONE) ? timer_pkg::RESP_DECERR
                 : timer_pkg::RESP_OKAY;
    end else if (rvalid & rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control register and overflow flags
  // ----------------------------------------------------------------
  // Flags only cleared by software writes
  assign ctrl_next.high_overflow_flag = hi_wrap |
    (wr_ctrl ? wbyte_reg[7]
             : (ctrl_reg.high_overflow_flag & ~stat_clr[timer_pkg::ST_HI]));
  // Low wrap sets its flag, set wins
  assign ctrl_next.low_overflow_flag = lo_wrap |
    (wr_ctrl ? wbyte_reg[6]
             : (ctrl_reg.low_overflow_flag & ~stat_clr[timer_pkg::ST_LO]));
  assign ctrl_next.low_interrupt_enable =
    wr_ctrl ? wbyte_reg[5] : ctrl_reg.low_interrupt_enable;
  // Capture is stored only; it steers nothing here
  assign ctrl_next.lf_capture_enable =
    wr_ctrl ? wbyte_reg[4] : ctrl_reg.lf_capture_enable;
  assign ctrl_next.split_mode_select =
    wr_ctrl ? wbyte_reg[3] : ctrl_reg.split_mode_select;
  assign ctrl_next.high_run_control =
    wr_ctrl ? wbyte_reg[2] : ctrl_reg.high_run_control;
  assign ctrl_next.unused = 1'b0;
  assign ctrl_next.external_clock_select =
    wr_ctrl ? wbyte_reg[0] : ctrl_reg.external_clock_select;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_reg      <= timer_pkg::CTRL_RST;
      reload_lo_reg <= timer_pkg::RELOAD_RST;
      reload_hi_reg <= timer_pkg::RELOAD_RST;
      clksel_reg    <= timer_pkg::CLKSEL_RST;
      core_ie_reg   <= timer_pkg::CORE_IE_RST;
      mask_reg      <= timer_pkg::MASK_RST;
      irq           <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      irq      <= irq_next;
      // Reloads take effect at next wrap
      if (wr_on && wsel == timer_pkg::SEL_RLO) begin
        reload_lo_reg <= wbyte_reg;
      end
      if (wr_on && wsel == timer_pkg::SEL_RHI) begin
        reload_hi_reg <= wbyte_reg;
      end
      if (wr_on && wsel == timer_pkg::SEL_CKS) begin
        clksel_reg <= wbyte_reg[1:0];
      end
      if (wr_on && wsel == timer_pkg::SEL_IE) begin
        core_ie_reg <= wbyte_reg[0];
      end
      if (wr_on && wsel == timer_pkg::SEL_MASK) begin
        mask_reg <= wbyte_reg[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  // Bit 3 chooses split or 16-bit
  assign split = ctrl_reg.split_mode_select;
  assign run   = ctrl_reg.high_run_control;

  tick_gen u_tick (
    .mclk    (mclk),
    .srst    (srst),
    .ext_osc (ext_osc),
    .ticks   (ticks)
  );

  // Each byte picks its counting clock
  assign tick_lo = pick_tick(clksel_reg[timer_pkg::CKS_LO],
                             ctrl_reg.external_clock_select, ticks);
  assign tick_hi = pick_tick(clksel_reg[timer_pkg::CKS_HI],
                             ctrl_reg.external_clock_select, ticks);

  // Low byte free-runs in split mode
  assign lo_inc = tick_lo & (split | run);
  // High byte takes the low carry in 16-bit mode, its own tick gated by run in split
  assign hi_inc = split ? (tick_hi & run) : lo_wrap;

  // Low reloads on full overflow in 16-bit mode, on every wrap in split
  byte_counter #(.WIDTH(8)) u_low (
    .mclk        (mclk),
    .srst        (srst),
    .wr_en       (wr_clo),
    .wr_val      (wbyte_reg),
    .inc         (lo_inc),
    .reload_wrap (split | hi_at_max),
    .reload_val  (reload_lo_reg),
    .count       (cnt_lo),
    .at_max      (lo_at_max),
    .wrap        (lo_wrap)
  );

  // High byte always reloads its own value
  byte_counter #(.WIDTH(8)) u_high (
    .mclk        (mclk),
    .srst        (srst),
    .wr_en       (wr_chi),
    .wr_val      (wbyte_reg),
    .inc         (hi_inc),
    .reload_wrap (1'b1),
    .reload_val  (reload_hi_reg),
    .count       (cnt_hi),
    .at_max      (hi_at_max),
    .wrap        (hi_wrap)
  );

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // High always, low only with enable
  assign evt = {ctrl_reg.low_overflow_flag &
                  ctrl_reg.low_interrupt_enable,
                ctrl_reg.high_overflow_flag};
  // Level request while an enabled flag stands
  assign irq_next = core_ie_reg & |(evt & mask_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence s_div12_gap;
    !ticks.sys_div12 [*8] ##1 !ticks.sys_div12 [*3] ##1 ticks.sys_div12;
  endsequence

  sequence s_low_carry;
    !split && lo_wrap && !hi_at_max && !wr_chi;
  endsequence

  a_div12_period: assert property (
    ticks.sys_div12 |=> s_div12_gap)
    else $error("divide-by-12 tick spacing wrong");
  a_ext_single: assert property (
    ticks.ext_div8 |=> !ticks.ext_div8)
    else $error("external tick longer than one cycle");
  a_full_reload: assert property (
    (!split && hi_wrap) |=>
      (cnt_hi == $past(reload_hi_reg) && cnt_lo == $past(reload_lo_reg)
       && ctrl_reg.high_overflow_flag))
    else $error("16-bit overflow did not reload and flag");
  a_carry_high: assert property (
    s_low_carry |=> (cnt_hi == $past(cnt_hi) + 8'h01 && cnt_lo == 8'h00))
    else $error("low byte carry not passed to high byte");
  a_irq_high: assert property (
    (core_ie_reg && mask_reg[timer_pkg::ST_HI]
     && ctrl_reg.high_overflow_flag) |=> irq)
    else $error("high overflow did not raise interrupt");
  a_irq_low: assert property (
    (core_ie_reg && mask_reg[timer_pkg::ST_LO]
     && ctrl_reg.low_interrupt_enable && ctrl_reg.low_overflow_flag)
    |=> irq)
    else $error("low overflow did not raise interrupt");
  a_irq_quiet: assert property (
    (!ctrl_reg.low_interrupt_enable && !ctrl_reg.high_overflow_flag)
    |=> !irq)
    else $error("interrupt without enabled cause");
  a_split_reload: assert property (
    (split && hi_wrap) |=> cnt_hi == $past(reload_hi_reg))
    else $error("split high byte missed reload");
  a_split_hold: assert property (
    (split && !run && !wr_chi) |=> $stable(cnt_hi))
    else $error("stopped high byte moved");
  a_low_free: assert property (
    (split && tick_lo && !lo_at_max && !wr_clo)
    |=> cnt_lo == $past(cnt_lo) + 8'h01)
    else $error("split low byte did not count");
  a_sys_select: assert property (
    (!clksel_reg[timer_pkg::CKS_LO] && !ctrl_reg.external_clock_select)
    |-> (tick_lo == ticks.sys_div12))
    else $error("low byte clock source wrong");
  a_flag_sticky: assert property (
    (ctrl_reg.low_overflow_flag && !wr_ctrl
     && !stat_clr[timer_pkg::ST_LO]) |=> ctrl_reg.low_overflow_flag)
    else $error("low flag cleared by hardware");
  a_set_wins: assert property (
    lo_wrap |=> ctrl_reg.low_overflow_flag)
    else $error("low wrap did not set flag");
  a_write_now: assert property (
    wr_clo |=> cnt_lo == $past(wbyte_reg))
    else $error("count write not immediate");

endmodule // auto_reload_timer

// File: dv/auto_reload_timer_split_mode_tb.sv
// Self-checking bench for the auto-reload timer, 16-bit and split modes.
// Assumes the design files are compiled first; AXI4-Lite master is here.
module auto_reload_timer_split_mode_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, srst, ext_osc, irq;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  int          n_fail, compares, i;
  logic [7:0]  rv;
  logic [7:0]  ra [9];
  logic [7:0]  rx [9];

  auto_reload_timer dut (.mclk(mclk), .srst(srst), .ext_osc(ext_osc),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));

  always #50 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Bit 1 of the control register always reads zero
  function automatic logic [31:0] ctrl_exp(input logic [7:0] w);
    return {24'h0, w & 8'hfd};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'hf);
    int k;
    @(posedge mclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wstrb <= s;
    wvalid <= 1'b1; bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (k == 50) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (k == 50) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic wait_irq(input int lim);
    int k;
    for (k = 0; k < lim && irq !== 1'b1; k++) @(posedge mclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    if (irq !== 1'b1) close_out();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0; srst = 1'b1; ext_osc = 1'b0;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
    wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0;
    rready = 1'b0; n_fail = 0; compares = 0;
    ra = '{timer_pkg::CTRL_OFS, timer_pkg::RELOAD_LO_OFS,
           timer_pkg::RELOAD_HI_OFS, timer_pkg::COUNT_LO_OFS,
           timer_pkg::COUNT_HI_OFS, timer_pkg::CLKSEL_OFS,
           timer_pkg::CORE_IE_OFS, timer_pkg::STATUS_OFS,
           timer_pkg::MASK_OFS};
    rx = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    void'($urandom(32'h93a8));
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    for (i = 0; i < 9; i++) begin
      rd(ra[i]);
      chk("reset value", {24'h0, rx[i]}, rdv);
    end
    rd(8'hf0);
    chk("unmapped read", {30'h0, timer_pkg::RESP_DECERR}, {30'h0, rsp});
    wr(8'hf0, 8'h55);
    chk("unmapped write", {30'h0, timer_pkg::RESP_DECERR}, {30'h0, rsp});
    // Random bytes into stopped counter and reload registers
    for (i = 0; i < 32; i++) begin
      rv = 8'($urandom);
      wr(ra[1 + i % 4], rv);
      rd(ra[1 + i % 4]);
      chk("byte readback", {24'h0, rv}, rdv);
    end
    // Last loop pass left rv in the high count byte
    wr(timer_pkg::COUNT_HI_OFS, ~rv, 4'h0);
    rd(timer_pkg::COUNT_HI_OFS);
    chk("strobe off", {24'h0, rv}, rdv);
    // No ext edges, so nothing counts while all bits are set
    wr(timer_pkg::CTRL_OFS, 8'hff);
    rd(timer_pkg::CTRL_OFS);
    chk("ctrl bits", ctrl_exp(8'hff), rdv);
    wr(timer_pkg::CTRL_OFS, 8'h00);
    rd(timer_pkg::CTRL_OFS);
    chk("ctrl cleared", 32'h00, rdv);
    // 16-bit, low byte on mclk, low wrap interrupt
    wr(timer_pkg::CLKSEL_OFS, 8'h01);
    wr(timer_pkg::CORE_IE_OFS, 8'h01);
    wr(timer_pkg::COUNT_HI_OFS, 8'h00);
    wr(timer_pkg::COUNT_LO_OFS, 8'hf0);
    wr(timer_pkg::CTRL_OFS, 8'h24);
    wait_irq(40);
    rd(timer_pkg::CTRL_OFS);
    chk("low wrap flags", 32'h64, rdv);
    wr(timer_pkg::CTRL_OFS, 8'h00);
    rd(timer_pkg::COUNT_HI_OFS);
    chk("carry to high", 32'h01, rdv);
    chk("irq after clear", 32'h0, {31'h0, irq});
    // 16-bit full wrap on mclk/12
    wr(timer_pkg::CLKSEL_OFS, 8'h00);
    wr(timer_pkg::RELOAD_LO_OFS, 8'h34);
    wr(timer_pkg::RELOAD_HI_OFS, 8'h12);
    wr(timer_pkg::COUNT_LO_OFS, 8'hff);
    wr(timer_pkg::COUNT_HI_OFS, 8'hff);
    wr(timer_pkg::CTRL_OFS, 8'h04);
    wait_irq(30);
    rd(timer_pkg::COUNT_LO_OFS);
    chk("reload low", 32'h34, rdv);
    rd(timer_pkg::COUNT_HI_OFS);
    chk("reload high", 32'h12, rdv);
    repeat (30) @(posedge mclk);
    rd(timer_pkg::CTRL_OFS);
    chk("flags sticky", 32'hc4, rdv);
    wr(timer_pkg::STATUS_OFS, 8'h03);
    rd(timer_pkg::CTRL_OFS);
    chk("status clear", 32'h04, rdv);
    chk("irq dropped", 32'h0, {31'h0, irq});
    // Rate of the mclk/12 source
    wr(timer_pkg::CTRL_OFS, 8'h00);
    wr(timer_pkg::COUNT_LO_OFS, 8'h00);
    wr(timer_pkg::CTRL_OFS, 8'h04);
    repeat (240) @(posedge mclk);
    wr(timer_pkg::CTRL_OFS, 8'h00);
    rd(timer_pkg::COUNT_LO_OFS);
    chk("div12 rate", 32'h1, {31'h0, rdv >= 19 && rdv <= 22});
    // External source: 16 rising pin edges give two ticks
    wr(timer_pkg::COUNT_LO_OFS, 8'h00);
    wr(timer_pkg::CTRL_OFS, 8'h05);
    repeat (16) begin
      ext_osc <= 1'b1;
      repeat (3) @(posedge mclk);
      ext_osc <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
    wr(timer_pkg::CTRL_OFS, 8'h00);
    rd(timer_pkg::COUNT_LO_OFS);
    chk("ext div8", 32'h02, rdv);
    // Split mode, high byte held by run bit
    wr(timer_pkg::CLKSEL_OFS, 8'h03);
    wr(timer_pkg::RELOAD_LO_OFS, 8'hf0);
    wr(timer_pkg::RELOAD_HI_OFS, 8'hfe);
    wr(timer_pkg::COUNT_HI_OFS, 8'h10);
    // Near the top so the low byte wraps well inside the wait
    wr(timer_pkg::COUNT_LO_OFS, 8'hf8);
    wr(timer_pkg::CTRL_OFS, 8'h08);
    repeat (60) @(posedge mclk);
    chk("split no len irq", 32'h0, {31'h0, irq});
    rd(timer_pkg::CTRL_OFS);
    chk("split low flag", 32'h48, rdv);
    rd(timer_pkg::COUNT_HI_OFS);
    chk("high held", 32'h10, rdv);
    rd(timer_pkg::COUNT_LO_OFS);
    chk("low reloads", 32'h1, {31'h0, rdv >= 32'hf0});
    wr(timer_pkg::CTRL_OFS, 8'h68);
    wait_irq(5);
    wr(timer_pkg::MASK_OFS, 8'h01);
    repeat (3) @(posedge mclk);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(timer_pkg::MASK_OFS, 8'h03);
    wr(timer_pkg::COUNT_HI_OFS, 8'hfe);
    wr(timer_pkg::CTRL_OFS, 8'h0c);
    repeat (4) @(posedge mclk);
    rd(timer_pkg::CTRL_OFS);
    chk("split high flag", 32'h8c, rdv & 32'h8f);
    wr(timer_pkg::CTRL_OFS, 8'h00);
    close_out();
  end
endmodule // auto_reload_timer_split_mode_tb
